// file: rtl/mrbps_pkg.sv
// Package: constants and carrier types of the retry/backoff/pad-strip block
package mrbps_pkg;

    // Register byte offsets
    localparam logic [7:0] MRBPS_CTRL_OFS     = 8'h00;  // Control bits
    localparam logic [7:0] MRBPS_STAT_OFS     = 8'h04;  // Engine state, read only
    localparam logic [7:0] MRBPS_INT_STS_OFS  = 8'h08;  // Sticky events, W1C
    localparam logic [7:0] MRBPS_INT_MASK_OFS = 8'h0c;  // Interrupt enables

    // Control register field positions
    localparam int MRBPS_CTRL_WAKE_BIT   = 0;   // wake_frame_detect_en
    localparam int MRBPS_CTRL_BACKOFF_LIMIT_SEL_LSB  = 6;   // backoff_limit_sel, bits 7-6
    localparam int MRBPS_CTRL_PAD_BIT    = 8;   // rx_pad_strip_en
    localparam int MRBPS_CTRL_SINGLE_BIT = 10;  // single_attempt_sel
    localparam int MRBPS_CTRL_BROADCAST_REJECT_BIT  = 11;  // broadcast_reject

    // Writable control bits and reset values
    localparam logic [31:0] MRBPS_CTRL_WMASK = 32'h0000_0dc1;
    localparam logic [31:0] MRBPS_CTRL_RST   = 32'h0000_0000;
    localparam logic [3:0]  MRBPS_MASK_RST   = 4'h0;

    // Interrupt status bit positions
    localparam int MRBPS_INT_TXOK   = 0;  // Frame sent
    localparam int MRBPS_INT_TXERR  = 1;  // Retry error
    localparam int MRBPS_INT_WAKE   = 2;  // Wake-up frame seen
    localparam int MRBPS_INT_RXDROP = 3;  // Broadcast rejected

    // Retry and backoff figures
    localparam int          MRBPS_MAX_ATTEMPTS = 16;
    localparam logic [3:0]  MRBPS_BACKOFF_CAP  = 4'd10;
    localparam logic [3:0]  MRBPS_LFSR_BITS_00 = 4'd10;
    localparam logic [3:0]  MRBPS_LFSR_BITS_01 = 4'd8;
    localparam logic [3:0]  MRBPS_LFSR_BITS_10 = 4'd4;
    localparam logic [3:0]  MRBPS_LFSR_BITS_11 = 4'd1;
    localparam logic [9:0]  MRBPS_LFSR_SEED    = 10'h001;

    // Slot time: 512 bit times at 100 Mb/s, waited at least in full
    localparam int MRBPS_SLOT_TIME_NS  = 5120;
    localparam int MRBPS_CLK_PERIOD_NS = 50;
    localparam int MRBPS_SLOT_CYCLES   =
        (MRBPS_SLOT_TIME_NS + MRBPS_CLK_PERIOD_NS - 1) / MRBPS_CLK_PERIOD_NS;

    // Receive frame layout
    localparam logic [10:0] MRBPS_HDR_LAST_IDX = 11'd13;  // Length field low byte
    localparam logic [15:0] MRBPS_MIN_PAYLOAD  = 16'd46;

    // AXI responses
    localparam logic [1:0] MRBPS_RESP_OKAY   = 2'b00;
    localparam logic [1:0] MRBPS_RESP_SLVERR = 2'b10;

    // Transmit engine states
    typedef enum logic [1:0] {MRBPS_TX_IDLE, MRBPS_TX_ATTEMPT, MRBPS_TX_BACKOFF} mrbps_tx_st_t;

    // Bus slave state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic [5:0]  aw_word;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mrbps_axi_t;

    // Transmit retry and backoff state
    typedef struct packed {
        mrbps_tx_st_t st;
        logic         go;
        logic [4:0]   attempts;
        logic [9:0]   slots;
        logic [6:0]   slot_cnt;
        logic         stat_vld;
        logic         retry_err;
    } mrbps_tx_t;

    // Receive path state
    typedef struct packed {
        logic [10:0] idx;
        logic [7:0]  len_hi;
        logic [15:0] len;
        logic        len_ok;
        logic        broadcast_reject;
        logic        cut;
        logic        vld;
        logic [7:0]  data;
        logic        last;
        logic        drop;
        logic        wake;
    } mrbps_rx_t;

    // Whole state of the block
    typedef struct packed {
        mrbps_axi_t  axi;
        mrbps_tx_t   tx;
        mrbps_rx_t   rx;
        logic [31:0] ctrl;
        logic [3:0]  sts;
        logic [3:0]  mask;
        logic        irq;
        logic [9:0]  lfsr;
    } mrbps_st_t;

endpackage : mrbps_pkg

// file: rtl/mrbps_top.sv
// Top: retry/backoff, pad strip, broadcast reject, wake and registers
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module mrbps_top
    import mrbps_pkg::*;
#(
    parameter int MAX_ATTEMPTS = MRBPS_MAX_ATTEMPTS,  // Tries per frame with retries allowed
    parameter int SLOT_CYCLES  = MRBPS_SLOT_CYCLES    // Clock cycles per slot time
) (
    input  wire logic        CLK_I,            // 20 MHz clock
    input  wire logic        RSTN_I,           // Synchronous reset, active low
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Transmit side
    input  wire logic        TX_REQ_I,         // Frame waiting
    input  wire logic        TX_COL_I,         // Collision
    input  wire logic        TX_END_I,         // Clean end
    output logic             TX_GO_O,          // Transmit attempt in progress
    output logic             TX_STAT_VALID_O,  // Frame done, pop queue
    output logic             TX_RETRY_ERR_O,   // Status: frame abandoned
    // Receive byte stream
    input  wire logic        RX_VALID_I,
    input  wire logic [7:0]  RX_DATA_I,
    input  wire logic        RX_LAST_I,
    input  wire logic        RX_WAKE_MATCH_I,  // Wake match, with last
    output logic             RX_VALID_O,
    output logic [7:0]       RX_DATA_O,
    output logic             RX_LAST_O,
    output logic             RX_DROP_O,        // Rejected, with last
    output logic             WAKE_O,           // Wake-up event pulse
    output logic             IRQ_O             // Level interrupt
);

    // Refuse parameters the counters cannot hold
    if (MAX_ATTEMPTS < 1 || MAX_ATTEMPTS > 31) begin : g_chk_att
        $error("MAX_ATTEMPTS must lie in 1..31");
    end
    if (SLOT_CYCLES < 1 || SLOT_CYCLES > 128) begin : g_chk_slot
        $error("SLOT_CYCLES must lie in 1..128");
    end

    localparam logic [4:0] MAX_ATT = 5'(MAX_ATTEMPTS);
    localparam logic [6:0] SLOT_RELOAD = 7'(SLOT_CYCLES - 1);

    mrbps_st_t s_q;  // Registered state
    mrbps_st_t s_d;  // Next state

    // Merge a write under byte strobes
    function automatic logic [31:0] mrbps_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : mrbps_merge

    // All next-state logic
    always_comb begin
        logic [31:0] wr_word;   // Merged write data
        logic [3:0]  sts_clr;   // Write-one-to-clear bits
        logic [3:0]  ev;        // Events raised this cycle
        logic [7:0]  rd_adr;    // Read byte address
        logic [4:0]  att;       // Attempts so far including this one
        logic [3:0]  k_exp;     // Backoff exponent
        logic [3:0]  lim_bits;  // Bits allowed by the limit field
        logic [3:0]  use_bits;  // Smaller of the two
        logic [10:0] mask_w;    // Random value mask
        logic        keep;      // Receive byte passes on
        logic        cut_now;   // Last kept byte of a stripped frame
        logic [15:0] len_now;   // Length field as known this byte
        logic        len_now_ok;
        logic        strip;     // Pad strip applies to this frame

        s_d = s_q;
        wr_word = '0;
        sts_clr = '0;
        ev = '0;
        rd_adr = '0;
        att = '0;
        k_exp = '0;
        lim_bits = '0;
        use_bits = '0;
        mask_w = '0;
        keep = 1'b0;
        cut_now = 1'b0;
        len_now = s_q.rx.len;
        len_now_ok = s_q.rx.len_ok;
        strip = 1'b0;

        // Pulses default low
        s_d.tx.stat_vld = 1'b0;
        s_d.tx.retry_err = 1'b0;
        s_d.rx.vld = 1'b0;
        s_d.rx.last = 1'b0;
        s_d.rx.drop = 1'b0;
        s_d.rx.wake = 1'b0;

        // Free-running LFSR, so the draw depends on when the collision lands
        s_d.lfsr = {s_q.lfsr[8:0], s_q.lfsr[9] ^ s_q.lfsr[6]};

        // Address and data taken in either order
        if (S_AXI_AWVALID && s_q.axi.awready) begin
            s_d.axi.aw_have = 1'b1;
            s_d.axi.aw_word = S_AXI_AWADDR[7:2];
        end
        if (S_AXI_WVALID && s_q.axi.wready) begin
            s_d.axi.w_have = 1'b1;
            s_d.axi.wdata = S_AXI_WDATA;
            s_d.axi.wstrb = S_AXI_WSTRB;
        end
        // Both halves held: write and answer
        if (s_q.axi.aw_have && s_q.axi.w_have) begin
            s_d.axi.aw_have = 1'b0;
            s_d.axi.w_have = 1'b0;
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp = MRBPS_RESP_OKAY;
            unique case ({s_q.axi.aw_word, 2'b00})
                MRBPS_CTRL_OFS: begin
                    wr_word = mrbps_merge(s_q.ctrl, s_q.axi.wdata, s_q.axi.wstrb);
                    s_d.ctrl = wr_word & MRBPS_CTRL_WMASK;
                end
                MRBPS_INT_STS_OFS: begin
                    sts_clr = s_q.axi.wstrb[0] ? s_q.axi.wdata[3:0] : 4'h0;
                end
                MRBPS_INT_MASK_OFS: begin
                    if (s_q.axi.wstrb[0]) begin
                        s_d.mask = s_q.axi.wdata[3:0];
                    end
                end
                MRBPS_STAT_OFS: begin
                    // Read only, write ignored
                end
                default: begin
                    s_d.axi.bresp = MRBPS_RESP_SLVERR;  // Unmapped
                end
            endcase
        end
        if (s_q.axi.bvalid && S_AXI_BREADY) begin
            s_d.axi.bvalid = 1'b0;
        end
        // One write in flight until its response is taken
        s_d.axi.awready = ~s_d.axi.aw_have & ~s_d.axi.bvalid;
        s_d.axi.wready = ~s_d.axi.w_have & ~s_d.axi.bvalid;

        // Read channel
        if (S_AXI_ARVALID && s_q.axi.arready) begin
            rd_adr = {S_AXI_ARADDR[7:2], 2'b00};
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rresp = MRBPS_RESP_OKAY;
            unique case (rd_adr)
                MRBPS_CTRL_OFS:     s_d.axi.rdata = s_q.ctrl;
                MRBPS_STAT_OFS:     s_d.axi.rdata = {5'h0, s_q.tx.slots, 9'h0,
                                                     s_q.tx.attempts, 1'b0,
                                                     s_q.tx.st};
                MRBPS_INT_STS_OFS:  s_d.axi.rdata = {28'h0, s_q.sts};
                MRBPS_INT_MASK_OFS: s_d.axi.rdata = {28'h0, s_q.mask};
                default: begin
                    s_d.axi.rdata = '0;
                    s_d.axi.rresp = MRBPS_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.axi.rvalid && S_AXI_RREADY) begin
            s_d.axi.rvalid = 1'b0;
        end
        s_d.axi.arready = ~s_d.axi.rvalid;

        // Transmit retry engine
        unique case (s_q.tx.st)
            MRBPS_TX_IDLE: begin
                if (TX_REQ_I) begin
                    s_d.tx.st = MRBPS_TX_ATTEMPT;
                    s_d.tx.attempts = '0;
                end
            end
            MRBPS_TX_ATTEMPT: begin
                if (TX_COL_I) begin
                    att = s_q.tx.attempts + 5'd1;
                    s_d.tx.attempts = att;
                    if (s_q.ctrl[MRBPS_CTRL_SINGLE_BIT] || att >= MAX_ATT) begin
                        // Give up, report, move to next frame
                        s_d.tx.st = MRBPS_TX_IDLE;
                        s_d.tx.stat_vld = 1'b1;
                        s_d.tx.retry_err = 1'b1;
                        ev[MRBPS_INT_TXERR] = 1'b1;
                    end else begin
                        // Exponent is the retry count, capped
                        k_exp = (att > 5'(MRBPS_BACKOFF_CAP)) ? MRBPS_BACKOFF_CAP
                                                              : att[3:0];
                        unique case (s_q.ctrl[MRBPS_CTRL_BACKOFF_LIMIT_SEL_LSB +: 2])
                            2'b00: lim_bits = MRBPS_LFSR_BITS_00;
                            2'b01: lim_bits = MRBPS_LFSR_BITS_01;
                            2'b10: lim_bits = MRBPS_LFSR_BITS_10;
                            2'b11: lim_bits = MRBPS_LFSR_BITS_11;
                        endcase
                        use_bits = (k_exp < lim_bits) ? k_exp : lim_bits;
                        mask_w = (11'h001 << use_bits) - 11'h001;
                        s_d.tx.slots = s_q.lfsr & mask_w[9:0];
                        s_d.tx.slot_cnt = SLOT_RELOAD;
                        s_d.tx.st = MRBPS_TX_BACKOFF;
                    end
                end else if (TX_END_I) begin
                    s_d.tx.st = MRBPS_TX_IDLE;
                    s_d.tx.stat_vld = 1'b1;
                    ev[MRBPS_INT_TXOK] = 1'b1;
                end
            end
            MRBPS_TX_BACKOFF: begin
                // Count slots down, then retry
                if (s_q.tx.slots == 10'h0) begin
                    s_d.tx.st = MRBPS_TX_ATTEMPT;
                end else if (s_q.tx.slot_cnt == 7'h0) begin
                    s_d.tx.slots = s_q.tx.slots - 10'h1;
                    s_d.tx.slot_cnt = SLOT_RELOAD;
                end else begin
                    s_d.tx.slot_cnt = s_q.tx.slot_cnt - 7'h1;
                end
            end
            default: begin
                s_d.tx.st = MRBPS_TX_IDLE;
            end
        endcase
        s_d.tx.go = (s_d.tx.st == MRBPS_TX_ATTEMPT);

        // Receive path: one cycle of latency
        if (RX_VALID_I) begin
            if (s_q.rx.idx < 11'd6 && RX_DATA_I != 8'hff) begin
                s_d.rx.broadcast_reject = 1'b0;
            end
            if (s_q.rx.idx == MRBPS_HDR_LAST_IDX - 11'd1) begin
                s_d.rx.len_hi = RX_DATA_I;
            end
            if (s_q.rx.idx == MRBPS_HDR_LAST_IDX) begin
                len_now = {s_q.rx.len_hi, RX_DATA_I};
                len_now_ok = 1'b1;
                s_d.rx.len = len_now;
                s_d.rx.len_ok = 1'b1;
            end
            // Short length field: keep header and payload, drop pad and FCS
            strip = s_q.ctrl[MRBPS_CTRL_PAD_BIT] && len_now_ok
                    && (len_now < MRBPS_MIN_PAYLOAD);
            keep = ~s_q.rx.cut;
            cut_now = strip && ~s_q.rx.cut
                      && ({5'h0, s_q.rx.idx} == {5'h0, MRBPS_HDR_LAST_IDX} + len_now);
            if (cut_now) begin
                s_d.rx.cut = 1'b1;
            end
            if (keep) begin
                s_d.rx.vld = 1'b1;
                s_d.rx.data = RX_DATA_I;
                s_d.rx.last = RX_LAST_I | cut_now;
                // Reject verdict rides on the last byte
                s_d.rx.drop = (RX_LAST_I | cut_now) && s_d.rx.broadcast_reject
                              && s_q.ctrl[MRBPS_CTRL_BROADCAST_REJECT_BIT];
                ev[MRBPS_INT_RXDROP] = s_d.rx.drop;
            end
            if (s_q.rx.idx != 11'h7ff) begin
                s_d.rx.idx = s_q.rx.idx + 11'h1;
            end
            if (RX_LAST_I) begin
                // Wake matching ignores the broadcast reject setting
                s_d.rx.wake = s_q.ctrl[MRBPS_CTRL_WAKE_BIT] && RX_WAKE_MATCH_I;
                ev[MRBPS_INT_WAKE] = s_d.rx.wake;
                s_d.rx.idx = '0;
                s_d.rx.len_ok = 1'b0;
                s_d.rx.broadcast_reject = 1'b1;
                s_d.rx.cut = 1'b0;
            end
        end

        // Sticky status: set wins over clear
        s_d.sts = (s_q.sts & ~sts_clr) | ev;
        s_d.irq = |(s_d.sts & s_d.mask);
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            s_q <= '0;
            s_q.ctrl <= MRBPS_CTRL_RST;
            s_q.mask <= MRBPS_MASK_RST;
            s_q.lfsr <= MRBPS_LFSR_SEED;
            s_q.rx.broadcast_reject <= 1'b1;
            s_q.tx.st <= MRBPS_TX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs from the state register
    assign S_AXI_AWREADY = s_q.axi.awready;
    assign S_AXI_WREADY = s_q.axi.wready;
    assign S_AXI_BVALID = s_q.axi.bvalid;
    assign S_AXI_BRESP = s_q.axi.bresp;
    assign S_AXI_ARREADY = s_q.axi.arready;
    assign S_AXI_RVALID = s_q.axi.rvalid;
    assign S_AXI_RDATA = s_q.axi.rdata;
    assign S_AXI_RRESP = s_q.axi.rresp;
    assign TX_GO_O = s_q.tx.go;
    assign TX_STAT_VALID_O = s_q.tx.stat_vld;
    assign TX_RETRY_ERR_O = s_q.tx.retry_err;
    assign RX_VALID_O = s_q.rx.vld;
    assign RX_DATA_O = s_q.rx.data;
    assign RX_LAST_O = s_q.rx.last;
    assign RX_DROP_O = s_q.rx.drop;
    assign WAKE_O = s_q.rx.wake;
    assign IRQ_O = s_q.irq;

endmodule : mrbps_top

// file: sim/mrbps_checker.sv
// Checker: port-level assertions on retry, status and receive paths
`timescale 1ns/1ps
module mrbps_checker (
    input wire logic       CLK_I,           // Clock
    input wire logic       RSTN_I,          // Reset, low
    input wire logic       TX_COL_I,        // Collision
    input wire logic       TX_END_I,        // Clean end
    input wire logic       TX_GO_O,         // Attempt on
    input wire logic       TX_STAT_VALID_O, // Frame done
    input wire logic       TX_RETRY_ERR_O,  // Abandoned
    input wire logic       RX_VALID_I,      // Byte in
    input wire logic [7:0] RX_DATA_I,       // Data in
    input wire logic       RX_LAST_I,       // End in
    input wire logic       RX_WAKE_MATCH_I, // Wake verdict
    input wire logic       RX_VALID_O,      // Byte out
    input wire logic [7:0] RX_DATA_O,       // Data out
    input wire logic       RX_LAST_O,       // End out
    input wire logic       RX_DROP_O,       // Rejected
    input wire logic       WAKE_O           // Wake pulse
);
    // One clock domain
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Clean frame end steps
    sequence s_clean_end; TX_GO_O && TX_END_I && !TX_COL_I; endsequence
    sequence s_ok_stat; TX_STAT_VALID_O && !TX_RETRY_ERR_O; endsequence
    property p_clean_ok; s_clean_end |=> s_ok_stat; endproperty
    a_clean_ok: assert property (p_clean_ok) else $error("no good status");
    property p_err_stat; TX_RETRY_ERR_O |-> TX_STAT_VALID_O; endproperty
    a_err_stat: assert property (p_err_stat) else $error("error off status");
    // A collision ends the attempt
    property p_col_stop; TX_GO_O && TX_COL_I |=> !TX_GO_O; endproperty
    a_col_stop: assert property (p_col_stop) else $error("go after collision");
    property p_stat_once; TX_STAT_VALID_O |=> !TX_STAT_VALID_O; endproperty
    a_stat_once: assert property (p_stat_once) else $error("status too long");
    property p_stat_src; TX_STAT_VALID_O |-> $past(TX_GO_O && (TX_END_I || TX_COL_I)); endproperty
    a_stat_src: assert property (p_stat_src) else $error("stray status");
    // Bytes pass unaltered
    property p_rx_data; RX_VALID_O |-> $past(RX_VALID_I) && RX_DATA_O == $past(RX_DATA_I);
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("byte altered");
    property p_rx_last; $past(RX_VALID_I && RX_LAST_I) && RX_VALID_O |-> RX_LAST_O; endproperty
    a_rx_last: assert property (p_rx_last) else $error("frame end lost");
    property p_drop_last; RX_DROP_O |-> RX_VALID_O && RX_LAST_O; endproperty
    a_drop_last: assert property (p_drop_last) else $error("drop off end");
    property p_wake_src; WAKE_O |-> $past(RX_VALID_I && RX_LAST_I && RX_WAKE_MATCH_I); endproperty
    a_wake_src: assert property (p_wake_src) else $error("stray wake");
endmodule : mrbps_checker

// file: sim/mrbps_phy_model.sv
// Partner model: transceiver answering attempts
`timescale 1ns/1ps
module mrbps_phy_model (
    input  wire logic       clk_i,  // Block clock
    input  wire logic       rstn_i, // Sync reset, active low
    input  wire logic       go_i,   // Attempt in progress
    input  wire logic       stat_i, // Frame done
    input  wire logic [4:0] ncol_i, // Collisions per frame
    input  wire logic [2:0] lat_i,  // Verdict latency
    output logic            col_o,  // Collision pulse
    output logic            end_o   // Clean end pulse
);
    logic       go_q;  // Attempt edge finder
    logic       busy;  // Verdict pending
    logic [2:0] dly;   // Latency left
    logic [4:0] seen;  // Collisions given this frame
    // Pulses only during an attempt; idle low
    always @(posedge clk_i) begin
        go_q  <= go_i;
        col_o <= 1'b0;
        end_o <= 1'b0;
        if (!rstn_i || stat_i) seen <= 5'h0;
        if (!rstn_i) busy <= 1'b0;
        else if (go_i && !go_q) begin
            busy <= 1'b1;
            dly  <= lat_i;
        end else if (busy && dly != 3'h0) dly <= dly - 3'h1;
        else if (busy) begin
            busy  <= 1'b0;
            col_o <= seen < ncol_i;
            end_o <= seen >= ncol_i;
            if (seen < ncol_i) seen <= seen + 5'h1;
        end
    end
endmodule : mrbps_phy_model

// file: sim/mrbps_top_tb.sv
// Testbench: registers, retries and stripping against a reference
`timescale 1ns/1ps
module mrbps_top_tb;
    import mrbps_pkg::*;
    localparam int SC = 2; // Short slot, brief backoffs
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        req = 0, rxv = 0, rxl = 0, rxw = 0;
    logic        awr, wr, bv, arr, rv, col, tend, go, stv, rerr, rvo, rlo, rdo, wake, irq;
    logic [7:0]  awaddr = 0, araddr = 0, rxd = 0, rdo8;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  ncol = 0;
    logic [2:0]  lat = 0;
    int          errors = 0, check_count = 0, wakes = 0, wexp = 0, exp_q[$];
    always #25 clk = ~clk;
    mrbps_top #(.SLOT_CYCLES(SC)) i_dut (.CLK_I(clk), .RSTN_I(rstn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rready), .TX_REQ_I(req), .TX_COL_I(col), .TX_END_I(tend), .TX_GO_O(go),
        .TX_STAT_VALID_O(stv), .TX_RETRY_ERR_O(rerr), .RX_VALID_I(rxv), .RX_DATA_I(rxd),
        .RX_LAST_I(rxl), .RX_WAKE_MATCH_I(rxw), .RX_VALID_O(rvo), .RX_DATA_O(rdo8),
        .RX_LAST_O(rlo), .RX_DROP_O(rdo), .WAKE_O(wake), .IRQ_O(irq));
    mrbps_phy_model i_phy (.clk_i(clk), .rstn_i(rstn), .go_i(go), .stat_i(stv),
        .ncol_i(ncol), .lat_i(lat), .col_o(col), .end_o(tend));
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // Bus write, halves released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!bv);
        rsp = bresp;
        bready <= 0;
        @(posedge clk);
    endtask : axw
    // Bus read
    task automatic axr(input logic [7:0] a);
        araddr <= a; arv <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        rd = rdata; rsp = rresp;
        rready <= 0;
        @(posedge clk);
    endtask : axr
    // One frame through retries; gaps bounded by 2^K - 1 slots plus 3 cycles
    task automatic run_tx(input bit sgl, input int nc, input logic [1:0] lim);
        int rises, gap, k, bits;
        bit gq;
        rises = 0; gap = 0; gq = 0;
        bits = lim == 0 ? MRBPS_LFSR_BITS_00 : lim == 1 ? MRBPS_LFSR_BITS_01 :
               lim == 2 ? MRBPS_LFSR_BITS_10 : MRBPS_LFSR_BITS_11;
        axw(MRBPS_CTRL_OFS, 32'(sgl) << MRBPS_CTRL_SINGLE_BIT | 32'(lim) << 6);
        ncol <= nc[4:0]; lat <= 3'($urandom_range(4)); req <= 1;
        repeat (30000) begin
            @(posedge clk);
            if (go && !gq) begin
                k = rises < 10 ? rises : 10;
                k = k < bits ? k : bits;
                if (rises > 0) chk(gap <= ((1 << k) - 1) * SC + 3, 1, "backoff span");
                rises++;
            end
            gap = go ? 0 : gap + 1;
            gq = go;
            // Queue drops request at final verdict
            if (go && (tend || col && (sgl || rises == MRBPS_MAX_ATTEMPTS))) req <= 0;
            if (stv) break;
        end
        chk(rises, sgl ? 1 : nc < 16 ? nc + 1 : 16, "attempt count");
        chk(rerr, sgl ? nc > 0 : nc >= 16, "retry error");
        $display("tx test done, %0d attempts", rises);
    endtask : run_tx
    // One received frame; exp_q holds what must come out
    task automatic send(input int n, len, input bit bc, wm, strip, rej, wen);
        int keep;
        logic [7:0] b;
        axw(MRBPS_CTRL_OFS, 32'(wen) | 32'(strip) << 8 | 32'(rej) << 11);
        keep = strip && len < 46 ? 14 + len : n;
        wexp += wen && wm;
        for (int i = 0; i < n; i++) begin
            b = i < 6 ? (bc ? 8'hff : 8'h02) : i == 12 ? 8'(len >> 8) : i == 13 ? 8'(len) :
                8'($urandom);
            if (i < keep) exp_q.push_back({i == keep - 1 && bc && rej, i == keep - 1, b});
            rxv <= 1; rxd <= b; rxl <= i == n - 1; rxw <= wm;
            @(posedge clk);
        end
        rxv <= 0; rxl <= 0;
        repeat (3) @(posedge clk);
        chk(wakes, wexp, "wake count");
        chk(exp_q.size(), 0, "bytes missing");
        $display("rx test done, length %0d", len);
    endtask : send
    // Output bytes against reference
    always @(posedge clk) begin
        if (wake) wakes++;
        if (rvo) chk({rdo, rlo, rdo8}, exp_q.size() ? exp_q.pop_front() : -1,
                     "rx byte");
    end
    // Verdict
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // Watchdog beyond the longest run
    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        void'($urandom(32'ha6d9b77d));
        repeat (8) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        axr(MRBPS_CTRL_OFS);
        chk(rd, MRBPS_CTRL_RST, "control reset");
        axw(MRBPS_CTRL_OFS, 32'hffff_ffff);
        axr(MRBPS_CTRL_OFS);
        chk(rd, MRBPS_CTRL_WMASK, "control bits");
        axr(8'h10);
        chk({rd[29:0], rsp}, {30'h0, MRBPS_RESP_SLVERR}, "unmapped read");
        axw(8'h14, 32'h1);
        chk(rsp, MRBPS_RESP_SLVERR, "unmapped write");
        axw(MRBPS_INT_MASK_OFS, 32'h1);
        $display("register test done");
        run_tx(1, 1, 2'h0);
        chk(irq, 0, "masked error");
        run_tx(0, 3, 2'h0);
        chk(irq, 1, "sent interrupt");
        axr(MRBPS_INT_STS_OFS);
        chk(rd, 32'h3, "event bits");
        axw(MRBPS_INT_STS_OFS, 32'h1);
        chk(irq, 0, "cleared interrupt");
        for (int l = 0; l < 4; l++) run_tx(0, 20, 2'(l));
        send(60, 10, 0, 0, 1, 0, 0);
        send(64, 45, 0, 0, 1, 0, 0);
        send(64, 46, 0, 0, 1, 0, 0);
        send(60, 10, 0, 0, 0, 0, 0);
        send(64, 46, 1, 1, 0, 1, 1);
        send(64, 46, 1, 0, 0, 0, 1);
        stop_test();
    end
endmodule : mrbps_top_tb
bind mrbps_top mrbps_checker i_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .TX_COL_I(TX_COL_I),
    .TX_END_I(TX_END_I), .TX_GO_O(TX_GO_O), .TX_STAT_VALID_O(TX_STAT_VALID_O),
    .TX_RETRY_ERR_O(TX_RETRY_ERR_O), .RX_VALID_I(RX_VALID_I), .RX_DATA_I(RX_DATA_I),
    .RX_LAST_I(RX_LAST_I), .RX_WAKE_MATCH_I(RX_WAKE_MATCH_I), .RX_VALID_O(RX_VALID_O),
    .RX_DATA_O(RX_DATA_O), .RX_LAST_O(RX_LAST_O), .RX_DROP_O(RX_DROP_O), .WAKE_O(WAKE_O));
